// file: hdl/gdc_code_prio.sv
// gdc_code_prio: fixed priority selection of one diagnosis code
// assumes the fault vector is ordered highest priority first
module gdc_code_prio (
    input wire gdc_pkg::gdc_fault_t faults,
    output logic [15:0] code
);
    import gdc_pkg::*;

    // first active source wins, otherwise ready
    always_comb begin
        if (faults.supply) code = GDC_CODE_SUPPLY;
        else if (faults.motor_off) code = GDC_CODE_MOTOR_OFF;
        else if (faults.temp_high) code = GDC_CODE_TEMP_HIGH;
        else if (faults.temp_low) code = GDC_CODE_TEMP_LOW;
        else if (faults.cmd_bad) code = GDC_CODE_CMD_BAD;
        else if (faults.task_check) code = GDC_CODE_TASK_CHECK;
        else if (faults.plaus.pos_bad) code = GDC_CODE_POS_BAD;
        else if (faults.plaus.force_bad) code = GDC_CODE_FORCE_BAD;
        else if (faults.plaus.speed_bad) code = GDC_CODE_SPEED_BAD;
        else if (faults.plaus.window_bad) code = GDC_CODE_WINDOW_BAD;
        else if (faults.not_ref) code = GDC_CODE_NOT_REF;
        else code = GDC_CODE_READY;
    end

endmodule

// file: hdl/gdc_diag.sv
// gdc_diag: diagnosis code, transfer handshake and parameter adoption of the gripper
// assumes all inputs are synchronous to clk and the host drives one command word
//
// Operation
// - no fault and ready gives code zero
// - motor controller off gives motor-off code
// - supply missing or torque-off open gives supply code
// - temperature above limit gives over-temperature code
// - temperature below limit gives under-temperature code
// - failed task check blocks task, reports code
// - several command bits set gives invalid-command code
// - invalid-command code after restart until handshake of a valid transfer
// - implausible jaw positions give position code
// - implausible force gives force code
// - implausible speed gives speed code
// - implausible tolerance gives tolerance code
// - rejected data leave accepted parameters unchanged
// - acknowledge bit 12, host clears, device clears
// - unreferenced measuring system gives not-referenced code
module gdc_diag #(
    parameter logic signed [15:0] TEMP_HIGH = 16'sh0050,
    parameter logic signed [15:0] TEMP_LOW = 16'sh0005,
    parameter logic [15:0] POS_MAX = 16'hffff,
    parameter logic [7:0] FORCE_MIN = 8'h01,
    parameter logic [7:0] FORCE_MAX = 8'h64,
    parameter logic [7:0] SPEED_MIN = 8'h01,
    parameter logic [7:0] SPEED_MAX = 8'h64,
    parameter logic [15:0] WINDOW_MAX = 16'h03e8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] host_command_word,
    input wire gdc_pkg::gdc_pdata_t host_pdata,
    input wire gdc_pkg::gdc_health_t health,
    input wire logic signed [15:0] measured_temp,
    input wire logic motion_request,
    input wire logic task_check_fail,
    output logic [15:0] diag_code_r,
    output logic [15:0] product_state_word_r,
    output gdc_pkg::gdc_pdata_t active_pdata_r,
    output logic motion_start_r
);
    import gdc_pkg::*;

    gdc_hs_t hs_r;
    gdc_plaus_t plaus_now;
    gdc_plaus_t plaus_r;
    gdc_fault_t faults;
    logic [15:0] code_nxt;
    logic cmd_one_hot;
    logic cmd_multi;
    logic hs_take;
    logic hs_done;
    logic init_pend_r;
    logic last_ok_r;
    logic task_err_r;
    logic transfer_req;

    // command word decoding
    assign cmd_one_hot = (host_command_word != 16'h0000) &&
                         ((host_command_word & (host_command_word - 16'h0001)) == 16'h0000);
    assign cmd_multi = (host_command_word != 16'h0000) && !cmd_one_hot;
    assign transfer_req = host_command_word[GDC_CMD_TRANSFER_BIT];
    assign hs_take = (hs_r == GDC_HS_IDLE) && cmd_one_hot;
    assign hs_done = (hs_r == GDC_HS_ACK) && (host_command_word == 16'h0000);

    gdc_plaus_check #(
        .POS_MAX(POS_MAX),
        .FORCE_MIN(FORCE_MIN),
        .FORCE_MAX(FORCE_MAX),
        .SPEED_MIN(SPEED_MIN),
        .SPEED_MAX(SPEED_MAX),
        .WINDOW_MAX(WINDOW_MAX)
    ) u_plaus (
        .pdata(host_pdata),
        .flags(plaus_now)
    );

    // handshake state machine: acknowledge, wait for cleared command, complete
    always_ff @(posedge clk) begin
        if (rst) begin
            hs_r <= GDC_HS_IDLE;
        end else begin
            unique case (hs_r)
                GDC_HS_IDLE: begin
                    if (hs_take) hs_r <= GDC_HS_ACK;
                end
                GDC_HS_ACK: begin
                    if (hs_done) hs_r <= GDC_HS_IDLE;
                end
            endcase
        end
    end

    // plausibility result latched per transfer and held until the next one
    always_ff @(posedge clk) begin
        if (rst) begin
            plaus_r <= '0;
            last_ok_r <= 1'b0;
        end else if (hs_take && transfer_req) begin
            plaus_r <= plaus_now;
            last_ok_r <= (plaus_now == '0);
        end
    end

    // adopt process data only when every check passes
    always_ff @(posedge clk) begin
        if (rst) begin
            active_pdata_r <= '0;
        end else if (hs_take && transfer_req && (plaus_now == '0)) begin
            active_pdata_r <= host_pdata;
        end
    end

    // restart state held until a valid transfer completes its handshake
    always_ff @(posedge clk) begin
        if (rst) begin
            init_pend_r <= 1'b1;
        end else if (hs_done && last_ok_r) begin
            init_pend_r <= 1'b0;
        end
    end

    // task check failure is sticky until a handshake completes; a new failure wins
    always_ff @(posedge clk) begin
        if (rst) begin
            task_err_r <= 1'b0;
        end else if (motion_request && task_check_fail) begin
            task_err_r <= 1'b1;
        end else if (hs_done) begin
            task_err_r <= 1'b0;
        end
    end

    // motion starts only on a clean check with no reported fault
    always_ff @(posedge clk) begin
        if (rst) begin
            motion_start_r <= 1'b0;
        end else begin
            motion_start_r <= motion_request && !task_check_fail &&
                              (diag_code_r == GDC_CODE_READY);
        end
    end

    // gather live and held fault sources
    always_comb begin
        faults.supply = !health.supply_ok || !health.safe_torque_off_input;
        faults.motor_off = !health.motor_on;
        faults.temp_high = measured_temp > TEMP_HIGH;
        faults.temp_low = measured_temp < TEMP_LOW;
        faults.cmd_bad = cmd_multi || init_pend_r;
        faults.task_check = task_err_r;
        faults.plaus = plaus_r;
        faults.not_ref = !health.referenced;
    end

    gdc_code_prio u_prio (
        .faults(faults),
        .code(code_nxt)
    );

    // diagnosis code follows the conditions one cycle later
    always_ff @(posedge clk) begin
        if (rst) begin
            diag_code_r <= GDC_CODE_RESET;
        end else begin
            diag_code_r <= code_nxt;
        end
    end

    // state word: ready flag and transfer acknowledge
    always_ff @(posedge clk) begin
        if (rst) begin
            product_state_word_r <= GDC_STATE_RESET;
        end else begin
            product_state_word_r <= 16'h0000;
            product_state_word_r[GDC_STATE_READY_BIT] <= (code_nxt == GDC_CODE_READY);
            product_state_word_r[GDC_STATE_ACK_BIT] <= hs_take ||
                                                      ((hs_r == GDC_HS_ACK) && !hs_done);
        end
    end

    // assertions

    property p_ready_zero;
        @(posedge clk) disable iff (rst)
        (faults == '0) |=> (diag_code_r == GDC_CODE_READY);
    endproperty
    a_ready_zero: assert property (p_ready_zero)
        else $error("code not zero with no fault");

    property p_motor_off;
        @(posedge clk) disable iff (rst)
        (!health.motor_on && health.supply_ok && health.safe_torque_off_input)
            |=> (diag_code_r == GDC_CODE_MOTOR_OFF);
    endproperty
    a_motor_off: assert property (p_motor_off)
        else $error("motor off not reported");

    property p_supply;
        @(posedge clk) disable iff (rst)
        (!health.safe_torque_off_input || !health.supply_ok) |=> (diag_code_r == GDC_CODE_SUPPLY);
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply fault not reported");

    property p_temp_high;
        @(posedge clk) disable iff (rst)
        (measured_temp > TEMP_HIGH && health.motor_on && health.supply_ok &&
         health.safe_torque_off_input) |=> (diag_code_r == GDC_CODE_TEMP_HIGH);
    endproperty
    a_temp_high: assert property (p_temp_high)
        else $error("over temperature not reported");

    property p_temp_low;
        @(posedge clk) disable iff (rst)
        (measured_temp < TEMP_LOW && health.motor_on && health.supply_ok &&
         health.safe_torque_off_input) |=> (diag_code_r == GDC_CODE_TEMP_LOW);
    endproperty
    a_temp_low: assert property (p_temp_low)
        else $error("under temperature not reported");

    property p_task_block;
        @(posedge clk) disable iff (rst)
        (motion_request && task_check_fail) |=> !motion_start_r ##1
            (task_err_r || $past(hs_done));
    endproperty
    a_task_block: assert property (p_task_block)
        else $error("failed task started or not flagged");

    property p_cmd_multi;
        @(posedge clk) disable iff (rst)
        (cmd_multi && !faults.supply && !faults.motor_off && !faults.temp_high &&
         !faults.temp_low) |=> (diag_code_r == GDC_CODE_CMD_BAD);
    endproperty
    a_cmd_multi: assert property (p_cmd_multi)
        else $error("multi bit command not reported");

    property p_init_hold;
        @(posedge clk) disable iff (rst)
        (init_pend_r && !(hs_done && last_ok_r)) |=> init_pend_r;
    endproperty
    a_init_hold: assert property (p_init_hold)
        else $error("restart state left without handshake");

    property p_keep_params;
        @(posedge clk) disable iff (rst)
        (hs_take && plaus_now != '0) |=> $stable(active_pdata_r);
    endproperty
    a_keep_params: assert property (p_keep_params)
        else $error("rejected data adopted");

    property p_ack_cycle;
        @(posedge clk) disable iff (rst)
        hs_take |=> product_state_word_r[GDC_STATE_ACK_BIT] && (hs_r == GDC_HS_ACK);
    endproperty
    a_ack_cycle: assert property (p_ack_cycle)
        else $error("acknowledge not raised");

    property p_ack_clear;
        @(posedge clk) disable iff (rst)
        hs_done |=> !product_state_word_r[GDC_STATE_ACK_BIT] && (hs_r == GDC_HS_IDLE);
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("acknowledge not cleared on completion");

    property p_not_ref;
        @(posedge clk) disable iff (rst)
        (faults.not_ref && !faults.supply && !faults.motor_off && !faults.temp_high &&
         !faults.temp_low && !faults.cmd_bad && !faults.task_check && (faults.plaus == '0))
            |=> (diag_code_r == GDC_CODE_NOT_REF);
    endproperty
    a_not_ref: assert property (p_not_ref)
        else $error("not referenced code lost");

    property p_prio_pos;
        @(posedge clk) disable iff (rst)
        (plaus_r.pos_bad && (faults.supply || faults.motor_off)) |=>
            (diag_code_r != GDC_CODE_POS_BAD);
    endproperty
    a_prio_pos: assert property (p_prio_pos)
        else $error("plausibility code outranked supply or motor");

    // ready flag of the state word always agrees with the reported code
    property p_ready_bit;
        @(posedge clk) disable iff (rst)
        product_state_word_r[GDC_STATE_READY_BIT] == (diag_code_r == GDC_CODE_READY);
    endproperty
    a_ready_bit: assert property (p_ready_bit)
        else $error("ready flag disagrees with code");

    // held position failure is reported when nothing outranks it
    property p_pos_code;
        @(posedge clk) disable iff (rst)
        (plaus_r.pos_bad && !faults.supply && !faults.motor_off && !faults.temp_high &&
         !faults.temp_low && !faults.cmd_bad && !faults.task_check)
            |=> (diag_code_r == GDC_CODE_POS_BAD);
    endproperty
    a_pos_code: assert property (p_pos_code)
        else $error("position code not reported");

    // held tolerance failure is reported when it is the only data fault
    property p_window_code;
        @(posedge clk) disable iff (rst)
        (plaus_r.window_bad && !plaus_r.pos_bad && !plaus_r.force_bad &&
         !plaus_r.speed_bad && !faults.supply && !faults.motor_off && !faults.temp_high &&
         !faults.temp_low && !faults.cmd_bad && !faults.task_check)
            |=> (diag_code_r == GDC_CODE_WINDOW_BAD);
    endproperty
    a_window_code: assert property (p_window_code)
        else $error("tolerance code not reported");

    // acknowledge stands while the host still shows its request
    property p_ack_hold;
        @(posedge clk) disable iff (rst)
        ((hs_r == GDC_HS_ACK) && (host_command_word != 16'h0000)) |=>
            product_state_word_r[GDC_STATE_ACK_BIT];
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("acknowledge dropped before completion");

endmodule

// file: hdl/gdc_pkg.sv
// gdc_pkg: diagnosis codes, command and status bit positions, process data carriers
// assumes one synchronous clock domain shared by every user of the package
package gdc_pkg;

    // diagnosis code values
    localparam logic [15:0] GDC_CODE_READY = 16'h0000;
    localparam logic [15:0] GDC_CODE_MOTOR_OFF = 16'h0001;
    localparam logic [15:0] GDC_CODE_SUPPLY = 16'h0100;
    localparam logic [15:0] GDC_CODE_TEMP_HIGH = 16'h0101;
    localparam logic [15:0] GDC_CODE_TEMP_LOW = 16'h0102;
    localparam logic [15:0] GDC_CODE_TASK_CHECK = 16'h0206;
    localparam logic [15:0] GDC_CODE_CMD_BAD = 16'h0300;
    localparam logic [15:0] GDC_CODE_POS_BAD = 16'h0301;
    localparam logic [15:0] GDC_CODE_FORCE_BAD = 16'h0302;
    localparam logic [15:0] GDC_CODE_SPEED_BAD = 16'h0303;
    localparam logic [15:0] GDC_CODE_WINDOW_BAD = 16'h0304;
    localparam logic [15:0] GDC_CODE_NOT_REF = 16'h0305;

    // bit positions in the command and state words
    localparam int GDC_CMD_TRANSFER_BIT = 0;
    localparam int GDC_STATE_READY_BIT = 0;
    localparam int GDC_STATE_ACK_BIT = 12;

    // reset values
    localparam logic [15:0] GDC_CODE_RESET = GDC_CODE_CMD_BAD;
    localparam logic [15:0] GDC_STATE_RESET = 16'h0000;

    // process data written by the host
    typedef struct packed {
        logic [15:0] outer_jaw_position;
        logic [15:0] inner_jaw_position;
        logic [7:0] clamp_force_setting;
        logic [7:0] travel_speed_setting;
        logic [15:0] target_window_width;
    } gdc_pdata_t;

    // drive and supply health seen by the product
    typedef struct packed {
        logic motor_on;
        logic supply_ok;
        logic safe_torque_off_input;
        logic referenced;
    } gdc_health_t;

    // plausibility failures of one transfer
    typedef struct packed {
        logic pos_bad;
        logic force_bad;
        logic speed_bad;
        logic window_bad;
    } gdc_plaus_t;

    // every fault source, highest priority first
    typedef struct packed {
        logic supply;
        logic motor_off;
        logic temp_high;
        logic temp_low;
        logic cmd_bad;
        logic task_check;
        gdc_plaus_t plaus;
        logic not_ref;
    } gdc_fault_t;

    // handshake states
    typedef enum logic [0:0] {
        GDC_HS_IDLE,
        GDC_HS_ACK
    } gdc_hs_t;

endpackage

// file: hdl/gdc_plaus_check.sv
// gdc_plaus_check: combinational plausibility test of one set of process data
// assumes the limits are static while a transfer is evaluated
module gdc_plaus_check #(
    parameter logic [15:0] POS_MAX = 16'hffff,
    parameter logic [7:0] FORCE_MIN = 8'h01,
    parameter logic [7:0] FORCE_MAX = 8'h64,
    parameter logic [7:0] SPEED_MIN = 8'h01,
    parameter logic [7:0] SPEED_MAX = 8'h64,
    parameter logic [15:0] WINDOW_MAX = 16'h03e8
) (
    input wire gdc_pkg::gdc_pdata_t pdata,
    output gdc_pkg::gdc_plaus_t flags
);
    import gdc_pkg::*;

    // outer jaw must lie below the inner one and inside the stroke
    assign flags.pos_bad = (pdata.outer_jaw_position >= pdata.inner_jaw_position) ||
                           (pdata.inner_jaw_position > POS_MAX);
    // force and speed inside their percentage band
    assign flags.force_bad = (pdata.clamp_force_setting < FORCE_MIN) ||
                             (pdata.clamp_force_setting > FORCE_MAX);
    assign flags.speed_bad = (pdata.travel_speed_setting < SPEED_MIN) ||
                             (pdata.travel_speed_setting > SPEED_MAX);
    // tolerance acts both ways, so it is bounded by one limit
    assign flags.window_bad = pdata.target_window_width > WINDOW_MAX;

endmodule

// file: verification/gdc_host_model.sv
// gdc_host_model: host side of the cyclic process data exchange
// assumes one clock shared with the diagnosis block; drives on the falling edge
module gdc_host_model (
    input wire logic clk,
    input wire logic [15:0] product_state_word_r,
    output logic [15:0] host_command_word,
    output gdc_pkg::gdc_pdata_t host_pdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import gdc_pkg::*;

    // idle command word and blank data at time zero
    initial begin
        host_command_word = 16'h0000;
        host_pdata = '0;
    end

    // hold a raw command word, used for refused words
    task automatic hold(input logic [15:0] c);
        @(negedge clk);
        host_command_word = c;
    endtask

    // one full handshake: request, wait ack, clear, wait ack low
    task automatic transfer(input logic [15:0] c, input gdc_pdata_t d,
                            output int t_on, output int t_off);
        @(negedge clk);
        host_command_word = c;
        host_pdata = d;
        t_on = 0;
        do begin
            @(negedge clk);
            t_on++;
        end while (product_state_word_r[12] !== 1'b1 && t_on < 20);
        host_command_word = 16'h0000;
        host_pdata = ~d; // released data no longer shows the last value
        t_off = 0;
        do begin
            @(negedge clk);
            t_off++;
        end while (product_state_word_r[12] !== 1'b0 && t_off < 20);
    endtask
endmodule

// file: verification/gripper_diagnosis_coder_tb.sv
// gripper_diagnosis_coder_tb: self-checking bench of the diagnosis block
// assumes default limits of the design; host model drives the command side
module gripper_diagnosis_coder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gdc_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    gdc_health_t health = 4'b1111;
    logic signed [15:0] measured_temp = 16'sh0014;
    logic motion_request = 1'b0;
    logic task_check_fail = 1'b0;
    logic [15:0] host_command_word;
    gdc_pdata_t host_pdata;
    logic [15:0] diag_code_r;
    logic [15:0] product_state_word_r;
    gdc_pdata_t active_pdata_r;
    logic motion_start_r;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h4;
    logic [3:0] ht [9];
    logic signed [15:0] tt [9];
    gdc_pdata_t d;
    gdc_pdata_t prev;
    logic [15:0] c;

    // free running clock
    always #2 clk = ~clk;

    gdc_host_model host (
        .clk(clk),
        .product_state_word_r(product_state_word_r),
        .host_command_word(host_command_word),
        .host_pdata(host_pdata)
    );

    gdc_diag dut (
        .clk(clk),
        .rst(rst),
        .host_command_word(host_command_word),
        .host_pdata(host_pdata),
        .health(health),
        .measured_temp(measured_temp),
        .motion_request(motion_request),
        .task_check_fail(task_check_fail),
        .diag_code_r(diag_code_r),
        .product_state_word_r(product_state_word_r),
        .active_pdata_r(active_pdata_r),
        .motion_start_r(motion_start_r)
    );

    // xorshift source of repeatable values
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // random process data inside the accepted limits
    function automatic gdc_pdata_t good_pdata();
        gdc_pdata_t p;
        logic [31:0] r;
        r = xs();
        p.outer_jaw_position = {1'b0, r[14:0]};
        r = xs();
        p.inner_jaw_position = p.outer_jaw_position + 16'h0001 + {8'h00, r[7:0]};
        p.clamp_force_setting = 8'h01 + r[15:8] % 8'd100;
        p.travel_speed_setting = 8'h01 + r[23:16] % 8'd100;
        p.target_window_width = r[31:16] % 16'd1001;
        return p;
    endfunction

    // expected code of health and temperature, fixed priority
    function automatic logic [15:0] fault_code(gdc_health_t h, logic signed [15:0] t);
        if (!h.supply_ok || !h.safe_torque_off_input) return 16'h0100;
        if (!h.motor_on) return 16'h0001;
        if (t > 16'sh0050) return 16'h0101;
        if (t < 16'sh0005) return 16'h0102;
        if (!h.referenced) return 16'h0305;
        return 16'h0000;
    endfunction

    // expected code of one transferred data set
    function automatic logic [15:0] plaus_code(gdc_pdata_t p);
        if (!(p.outer_jaw_position < p.inner_jaw_position)) return 16'h0301;
        if (p.clamp_force_setting < 8'h01 || p.clamp_force_setting > 8'h64) return 16'h0302;
        if (p.travel_speed_setting < 8'h01 || p.travel_speed_setting > 8'h64) return 16'h0303;
        if (p.target_window_width > 16'h03e8) return 16'h0304;
        return 16'h0000;
    endfunction

    // single comparison point
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic summarize();
        if (err_total == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic settle();
        repeat (3) @(negedge clk);
    endtask

    // full handshake with latency checks
    task automatic do_xfer(input logic [15:0] cw, input gdc_pdata_t p);
        int t_on;
        int t_off;
        host.transfer(cw, p, t_on, t_off);
        chk(t_on, 1);
        chk(t_off, 1);
        repeat (2) @(negedge clk);
    endtask

    // watchdog
    initial begin
        #100000;
        err_total++;
        summarize();
    end

    // main sequence
    initial begin
        ht = '{4'b1011, 4'b1101, 4'b0111, 4'b1111, 4'b1111, 4'b1110, 4'b0011, 4'b1111, 4'b1111};
        tt = '{16'sh0014, 16'sh0014, 16'sh0014, 16'sh0051, 16'sh0004, 16'sh0014, 16'sh0051,
               16'sh0050, 16'sh0005};
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(diag_code_r, 16'h0300);
        chk(product_state_word_r, 16'h0000);
        settle();
        chk(diag_code_r, 16'h0300);
        // handshake without data keeps the restart code
        do_xfer(16'h0004, good_pdata());
        chk(diag_code_r, 16'h0300);
        chk(active_pdata_r, 64'h0);
        // random good transfers
        for (int i = 0; i < 4; i++) begin
            d = good_pdata();
            do_xfer(16'h0001, d);
            chk(active_pdata_r, d);
            chk(diag_code_r, 16'h0000);
            chk(product_state_word_r, 16'h0001);
        end
        // health and temperature table, boundaries included
        for (int i = 0; i < 9; i++) begin
            @(negedge clk);
            health = gdc_health_t'(ht[i]);
            measured_temp = tt[i];
            settle();
            chk(diag_code_r, fault_code(health, measured_temp));
            chk(product_state_word_r[0], fault_code(health, measured_temp) == 16'h0000);
        end
        @(negedge clk);
        health = 4'b1011;
        settle();
        chk(diag_code_r, 16'h0100);
        @(negedge clk);
        health = 4'b1111;
        settle();
        chk(diag_code_r, 16'h0000);
        // refused multi-bit command words
        c = 16'(xs());
        if ($countones(c) < 2) c = 16'h8001;
        host.hold(c);
        settle();
        chk(diag_code_r, 16'h0300);
        chk(product_state_word_r[12], 1'b0);
        host.hold(16'h0000);
        settle();
        chk(diag_code_r, 16'h0000);
        // implausible data are refused and held
        for (int k = 0; k < 4; k++) begin
            d = good_pdata();
            if (k == 0) d.outer_jaw_position = d.inner_jaw_position;
            if (k == 1) d.clamp_force_setting = 8'h00;
            if (k == 2) d.travel_speed_setting = 8'h65;
            if (k == 3) d.target_window_width = 16'h03e9;
            prev = active_pdata_r;
            do_xfer(16'h0001, d);
            chk(diag_code_r, plaus_code(d));
            chk(active_pdata_r, prev);
            if (k == 0) begin
                // motor fault outranks the held position failure
                health = 4'b0111;
                settle();
                chk(diag_code_r, 16'h0001);
                health = 4'b1111;
                settle();
                chk(diag_code_r, 16'h0301);
            end
        end
        settle();
        chk(diag_code_r, 16'h0304);
        d = good_pdata();
        do_xfer(16'h0001, d);
        chk(diag_code_r, 16'h0000);
        chk(active_pdata_r, d);
        // failed task check blocks the motion task
        motion_request = 1'b1;
        task_check_fail = 1'b1;
        @(negedge clk);
        motion_request = 1'b0;
        task_check_fail = 1'b0;
        chk(motion_start_r, 1'b0);
        settle();
        chk(diag_code_r, 16'h0206);
        motion_request = 1'b1;
        @(negedge clk);
        motion_request = 1'b0;
        chk(motion_start_r, 1'b0);
        do_xfer(16'h0001, good_pdata());
        chk(diag_code_r, 16'h0000);
        motion_request = 1'b1;
        @(negedge clk);
        motion_request = 1'b0;
        chk(motion_start_r, 1'b1);
        @(negedge clk);
        chk(motion_start_r, 1'b0);
        // restart in mid-run brings back the initial code and clears accepted data
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(diag_code_r, 16'h0300);
        chk(active_pdata_r, 64'h0);
        settle();
        chk(diag_code_r, 16'h0300);
        d = good_pdata();
        do_xfer(16'h0001, d);
        chk(diag_code_r, 16'h0000);
        chk(active_pdata_r, d);
        summarize();
    end
endmodule
